// ==== src/period_match_timer8.sv ====
// 8-bit period-match timer with prescaler, postscaler and AXI4-Lite registers.
// Assumes clk is the oscillator clock and reset covers every device reset.
//
// Overview of operation
// R1: Counter is clocked from oscillator over four through a 1, 4 or 16 prescaler.
// R2: Prescale select 00 divides by one, 01 by four, 1x by sixteen.
// R3: Counter climbs from zero to the period value, then reloads zero next tick.
// R4: Period register is read/write and resets to all ones.
// R5: Matches pass a 4-bit postscaler whose completion sets the latched match flag.
// R6: Postscale ratio is the control field bits 6-3 plus one.
// R7: Count writes, control writes and reset clear prescaler and postscaler.
// R8: A control write leaves the count value untouched.
// R9: Count register is read/write and resets to zero.
// R10: Counting happens only while the on bit is set.
// R11: Control bit 7 reads zero; other control bits reset to zero.
// R12: Match pulse is offered as the PWM time base.
// R13: Match output goes to the synchronous serial port for its shift clock.
// R14: Serial port match pulse is taken before the postscaler.
// R15: Match flag stays set until software clears it; repeats keep it set.
// R16: Postscaler advances per match and restarts after the selected ratio.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
module period_match_timer8 (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [period_timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [period_timer_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [period_timer_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [period_timer_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt
  output logic irq,
  // Serial port shift clock source
  output logic serialMatchPulse,
  // PWM time base
  output logic pwmPeriodPulse,
  output logic [7:0] pwmCount
);
  import period_timer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg_access_if acc ();

  logic [1:0] instrDiv_ff;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [7:0] period_ff;
  logic [3:0] outps_ff;
  logic timerOn_ff;
  logic [1:0] ckps_ff;
  logic flag_ff;
  logic nxt_flag;
  logic mask_ff;
  logic irq_ff;
  logic serialMatch_ff;
  logic pwmPulse_ff;
  logic [3:0] preLast;
  logic [3:0] preCount;
  logic [3:0] postCount;
  logic countTick;
  logic flagEvent;
  logic wrHit;
  logic wrCount;
  logic wrPeriod;
  logic wrControl;
  logic wrMask;
  logic rdCount;
  logic rdPeriod;
  logic rdControl;
  logic rdStatus;
  logic rdMask;
  logic rdState;
  logic [7:0] controlView;
  logic [7:0] statusView;
  logic [7:0] maskView;
  logic [7:0] stateView;
  logic [7:0] rdMux;
  logic statusReadClear;
  logic instrTick;
  logic preStep;
  logic scalerClear;
  logic atPeriod;
  logic matchNow;
  logic maskNext;

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end

  axil_reg_port busPort (
    .clk(clk),
    .reset(reset),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .acc(acc.port)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  // Registers are one byte wide, so only lane 0 carries data

  assign wrHit = acc.wrEn && acc.wrLow;

  always_comb begin
    wrCount = 1'b0;
    wrPeriod = 1'b0;
    wrControl = 1'b0;
    wrMask = 1'b0;
    if (wrHit) begin
      if (acc.wrAddr == OFF_COUNT) begin
        wrCount = 1'b1;
      end else if (acc.wrAddr == OFF_PERIOD) begin
        wrPeriod = 1'b1;
      end else if (acc.wrAddr == OFF_CONTROL) begin
        wrControl = 1'b1;
      end else if (acc.wrAddr == OFF_MASK) begin
        wrMask = 1'b1;
      end
    end
  end

  // Status and state are read-only; writes there are quietly dropped
  assign acc.wrOk = (acc.wrAddr == OFF_COUNT) || (acc.wrAddr == OFF_PERIOD) ||
                    (acc.wrAddr == OFF_CONTROL) || (acc.wrAddr == OFF_STATUS) ||
                    (acc.wrAddr == OFF_MASK) || (acc.wrAddr == OFF_STATE);

  //////////////////////////////////////////////////////////////////////////////
  // Read decode

  assign rdCount = acc.rdAddr == OFF_COUNT;
  assign rdPeriod = acc.rdAddr == OFF_PERIOD;
  assign rdControl = acc.rdAddr == OFF_CONTROL;
  assign rdStatus = acc.rdAddr == OFF_STATUS;
  assign rdMask = acc.rdAddr == OFF_MASK;
  assign rdState = acc.rdAddr == OFF_STATE;

  // Bit 7 of control has no storage and reads zero
  assign controlView = {1'b0, outps_ff, timerOn_ff, ckps_ff}; // R11
  assign statusView = {6'h00, flag_ff, 1'b0};
  assign maskView = {6'h00, mask_ff, 1'b0};
  assign stateView = {postCount, preCount};

  assign acc.rdOk = rdCount || rdPeriod || rdControl || rdStatus || rdMask || rdState;

  // Unmapped addresses read zero so software never sees stale bytes
  always_comb begin
    rdMux = 8'h00;
    if (rdCount) begin
      rdMux = count_ff; // R9
    end else if (rdPeriod) begin
      rdMux = period_ff; // R4
    end else if (rdControl) begin
      rdMux = controlView; // R11
    end else if (rdStatus) begin
      rdMux = statusView;
    end else if (rdMask) begin
      rdMux = maskView;
    end else if (rdState) begin
      rdMux = stateView;
    end
  end

  assign acc.rdData = rdMux;

  // Reading status is how software clears the flag
  // Cleared at acceptance, so a stalled rready cannot clear it twice
  assign statusReadClear = acc.rdEn && rdStatus;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction clock
  // Free running; only the scalers restart on writes, so the first tick after
  // a write may come up to three clocks early

  always_ff @(posedge clk) begin
    if (reset) instrDiv_ff <= 2'h0;
    else instrDiv_ff <= instrDiv_ff + 2'h1;
  end

  assign instrTick = instrDiv_ff == INSTR_LAST; // R1

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler

  // Either code with the upper bit set gives sixteen
  assign preLast = (ckps_ff == CKPS_DIV1) ? PRE_LAST_DIV1 : // R2
                   (ckps_ff == CKPS_DIV4) ? PRE_LAST_DIV4 : PRE_LAST_DIV16; // R2

  // Stopping the instruction ticks here also freezes the prescaler
  assign preStep = instrTick && timerOn_ff; // R10

  // Count and control writes restart both scalers; reset does so inside
  assign scalerClear = wrCount || wrControl; // R7

  event_scaler prescaler (
    .clk(clk),
    .reset(reset),
    .clear(scalerClear),
    .step(preStep),
    .lastIdx(preLast),
    .count(preCount),
    .done(countTick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Period counter

  assign atPeriod = count_ff == period_ff;
  assign matchNow = countTick && atPeriod;

  // A software write wins over a tick in the same cycle; control writes
  // never touch the count
  assign nxt_count = wrCount ? acc.wrData : // R9 R8
                     matchNow ? COUNT_RESET : // R3
                     countTick ? count_ff + 8'h01 : count_ff; // R3

  always_ff @(posedge clk) begin
    if (reset) count_ff <= COUNT_RESET; // R9
    else count_ff <= nxt_count;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Period register

  always_ff @(posedge clk) begin
    if (reset) period_ff <= PERIOD_RESET; // R4
    else if (wrPeriod) period_ff <= acc.wrData; // R4
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge clk) begin
    if (reset) begin
      outps_ff <= CONTROL_RESET[CTL_OUTPS_MSB:CTL_OUTPS_LSB]; // R11
      timerOn_ff <= CONTROL_RESET[CTL_ON_BIT];
      ckps_ff <= CONTROL_RESET[CTL_CKPS_LSB+1:CTL_CKPS_LSB];
    end else if (wrControl) begin
      outps_ff <= acc.wrData[CTL_OUTPS_MSB:CTL_OUTPS_LSB];
      timerOn_ff <= acc.wrData[CTL_ON_BIT];
      ckps_ff <= acc.wrData[CTL_CKPS_LSB+1:CTL_CKPS_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Postscaler
  // Field value is the last index, so the ratio is the field plus one

  event_scaler postscaler (
    .clk(clk),
    .reset(reset),
    .clear(scalerClear), // R7
    .step(matchNow), // R16
    .lastIdx(outps_ff), // R6
    .count(postCount),
    .done(flagEvent) // R5 R16
  );

  //////////////////////////////////////////////////////////////////////////////
  // Match flag and interrupt
  // A completion landing on the clearing read keeps the flag set

  assign nxt_flag = flagEvent || (flag_ff && !statusReadClear); // R5 R15

  always_ff @(posedge clk) begin
    if (reset) flag_ff <= 1'b0;
    else flag_ff <= nxt_flag;
  end

  always_ff @(posedge clk) begin
    if (reset) mask_ff <= MASK_RESET[FLAG_BIT];
    else if (wrMask) mask_ff <= acc.wrData[FLAG_BIT];
  end

  // Mask write takes effect with the register, so irq never lags the mask
  assign maskNext = wrMask ? acc.wrData[FLAG_BIT] : mask_ff;

  // Built from the next flag value so irq tracks the flag without lag
  always_ff @(posedge clk) begin
    if (reset) irq_ff <= 1'b0;
    else irq_ff <= nxt_flag && maskNext;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Exported match pulses
  // Taken ahead of the postscaler so every match is seen

  always_ff @(posedge clk) begin
    if (reset) begin
      serialMatch_ff <= 1'b0;
      pwmPulse_ff <= 1'b0;
    end else begin
      serialMatch_ff <= matchNow; // R13 R14
      pwmPulse_ff <= matchNow; // R12
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign irq = irq_ff;
  assign serialMatchPulse = serialMatch_ff;
  assign pwmPeriodPulse = pwmPulse_ff;
  assign pwmCount = count_ff;
endmodule

// ==== pkg/period_timer_pkg.sv ====
// Constants shared by the period-match timer, its bus port and its scalers.
// Assumes a 50 MHz clk that stands in for the oscillator clock.
package period_timer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h14;
  //////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTL_CKPS_LSB = 0;
  localparam int CTL_ON_BIT = 2;
  localparam int CTL_OUTPS_LSB = 3;
  localparam int CTL_OUTPS_MSB = 6;
  // Status and mask layout
  localparam int FLAG_BIT = 1;
  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  //////////////////////////////////////////////////////////////////////////////
  // Instruction clock is oscillator over four
  localparam logic [1:0] INSTR_LAST = 2'h3;
  // Prescaler last index per select code
  localparam logic [1:0] CKPS_DIV1 = 2'h0;
  localparam logic [1:0] CKPS_DIV4 = 2'h1;
  localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;
  //////////////////////////////////////////////////////////////////////////////
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== pkg/reg_access_if.sv ====
// Register access strobes between the bus port and the timer core.
// Assumes one clock; every strobe lasts a single cycle.
interface reg_access_if;
  logic wrEn;
  logic [period_timer_pkg::ADDR_W-1:0] wrAddr;
  logic [7:0] wrData;
  logic wrLow;
  logic wrOk;
  logic rdEn;
  logic [period_timer_pkg::ADDR_W-1:0] rdAddr;
  logic [7:0] rdData;
  logic rdOk;
  modport port (
    output wrEn, wrAddr, wrData, wrLow, rdEn, rdAddr,
    input wrOk, rdOk, rdData
  );
  modport regs (
    input wrEn, wrAddr, wrData, wrLow, rdEn, rdAddr,
    output wrOk, rdOk, rdData
  );
endinterface

// ==== src/event_scaler.sv ====
// Clearable event divider: counts step pulses, fires on the last index.
// Assumes step and clear are single-cycle strobes in the clk domain.
module event_scaler (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [3:0] lastIdx,
  // State and result
  output logic [3:0] count,
  output logic done
);
  import period_timer_pkg::*;

  logic [3:0] count_ff;
  logic [3:0] nxt_count;

  assign done = step && !clear && (count_ff >= lastIdx);
  // Clear beats a step in the same cycle
  assign nxt_count = clear ? 4'h0 : done ? 4'h0 : step ? count_ff + 4'h1 : count_ff;
  assign count = count_ff;

  always_ff @(posedge clk) begin
    if (reset) count_ff <= 4'h0;
    else count_ff <= nxt_count;
  end
endmodule

// ==== src/axil_reg_port.sv ====
// AXI4-Lite slave front end turning bus beats into register strobes.
// Assumes one write and one read outstanding; registers sit in the low byte.
module axil_reg_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write address and data
  input wire logic [period_timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [period_timer_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read
  input wire logic [period_timer_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [period_timer_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  reg_access_if.port acc
);
  import period_timer_pkg::*;

  logic awready_ff, wready_ff, bvalid_ff, awHeld_ff, wHeld_ff, wLow_ff;
  logic arready_ff, rvalid_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0] wData_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [DATA_W-1:0] rdata_ff;
  wire awTake = awvalid && awready_ff;
  wire wTake = wvalid && wready_ff;
  wire doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
  wire arTake = arvalid && arready_ff;

  assign acc.wrEn = doWrite;
  assign acc.wrAddr = awAddr_ff;
  assign acc.wrData = wData_ff;
  assign acc.wrLow = wLow_ff;
  assign acc.rdEn = arTake;
  assign acc.rdAddr = araddr;
  assign {awready, wready, bvalid, bresp} = {awready_ff, wready_ff, bvalid_ff, bresp_ff};
  assign {arready, rvalid, rresp, rdata} = {arready_ff, rvalid_ff, rresp_ff, rdata_ff};

  //////////////////////////////////////////////////////////////////////////////
  // Address and data may arrive in either order; ready drops until the response
  always_ff @(posedge clk) begin
    if (reset) begin
      {awready_ff, wready_ff, bvalid_ff, awHeld_ff, wHeld_ff, wLow_ff} <= 6'h30;
      awAddr_ff <= '0;
      wData_ff <= 8'h00;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (awTake) {awAddr_ff, awHeld_ff, awready_ff} <= {awaddr, 2'h2};
      else if (doWrite) awHeld_ff <= 1'b0;
      if (wTake) {wData_ff, wLow_ff, wHeld_ff, wready_ff} <= {wdata[7:0], wstrb[0], 2'h2};
      else if (doWrite) wHeld_ff <= 1'b0;
      if (doWrite) {bvalid_ff, bresp_ff} <= {1'b1, acc.wrOk ? RESP_OKAY : RESP_SLVERR};
      else if (bvalid_ff && bready) {bvalid_ff, awready_ff, wready_ff} <= 3'h3;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data registered at acceptance, so read side effects fire once
  always_ff @(posedge clk) begin
    if (reset) begin
      {arready_ff, rvalid_ff} <= 2'h2;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (arTake) begin
      {arready_ff, rvalid_ff} <= 2'h1;
      rresp_ff <= acc.rdOk ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= {24'h000000, acc.rdData};
    end else if (rvalid_ff && rready) begin
      {arready_ff, rvalid_ff} <= 2'h2;
    end
  end
endmodule

// ==== testbench/period_match_timer8_props.sv ====
// Port-level assertions for the period-match timer.
// Assumes a bind from the bench; sees only top-level ports.
module period_match_timer8_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [period_timer_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Timer outputs
  input wire logic irq,
  input wire logic serialMatchPulse,
  input wire logic pwmPeriodPulse,
  input wire logic [7:0] pwmCount
);
  import period_timer_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  a_pulse_pair: assert property (serialMatchPulse == pwmPeriodPulse)
    else $error("match pulses differ");
  // Ticks come every fourth clk at best
  a_pulse_gap: assert property (serialMatchPulse |=> !serialMatchPulse [*3])
    else $error("match pulses too close");
  a_wrap_zero: assert property (serialMatchPulse && !bvalid && !$past(bvalid)
    |-> (pwmCount == 8'h00) or (##1 pwmCount == 8'h00))
    else $error("match without wrap to zero");
  // Writes excluded: they load any value
  a_count_step: assert property ($changed(pwmCount) && !bvalid && !$past(bvalid)
    |-> pwmCount == $past(pwmCount) + 8'h01 || pwmCount == 8'h00)
    else $error("count jumped");
  a_irq_cause: assert property ($rose(irq) |-> serialMatchPulse || bvalid
    || $past(bvalid)) else $error("irq rose without cause");
  a_irq_sticky: assert property ($fell(irq) |-> rvalid || $past(rvalid)
    || bvalid || $past(bvalid)) else $error("irq dropped on its own");
  a_wr_latency: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !wready ##1 bvalid) else $error("write answer late");
  a_rd_latency: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  //////////////////////////////////////////////////////////////////////////////
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
  c_fast: cover property (serialMatchPulse ##4 serialMatchPulse);
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the period-match timer over AXI4-Lite.
// Assumes the package and the checker file are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import period_timer_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata, rdv;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, serialMatchPulse, pwmPeriodPulse;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] pwmCount, per;
  logic [3:0] post;
  int err_total = 0;
  int total_checks = 0;
  int seed = 34;
  int g, n;
  period_match_timer8 u_dut (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .serialMatchPulse(serialMatchPulse), .pwmPeriodPulse(pwmPeriodPulse),
    .pwmCount(pwmCount));
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Ready is held back at random so slow masters are covered too
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bit aw, w;
    int k;
    aw = 1'b0;
    w = 1'b0;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w) && k++ < 100) begin
      @(posedge clk);
      if (awready && !aw) aw = 1'b1;
      if (wready && !w) w = 1'b1;
      awvalid <= !aw;
      wvalid <= !w;
    end
    repeat ($unsigned($random(seed)) % 3) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid && k++ < 200);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready && k++ < 100);
    arvalid <= 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid && k++ < 200);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdv, exp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask
  task automatic reset_vals();
    rc(OFF_COUNT, 32'h0);
    rc(OFF_PERIOD, 32'hff);
    rc(OFF_CONTROL, 32'h0);
    rc(OFF_MASK, 32'h0);
    rc(OFF_STATUS, 32'h0);
    rc(OFF_STATE, 32'h0);
  endtask
  function automatic int gap(input logic [7:0] p, input logic [1:0] ps);
    return (int'(p) + 1) * 4 * (ps == 2'h0 ? 1 : ps == 2'h1 ? 4 : 16);
  endfunction
  // Times the span between two consecutive match pulses
  task automatic pulse_gap();
    g = 0;
    do @(posedge clk); while (!serialMatchPulse && g++ < 20000);
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (!serialMatchPulse && g < 20000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    reset_vals();
    rd(8'h18);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk(rdv, 32'h0);
    wr(8'h05, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    per = 8'($random(seed));
    wr(OFF_PERIOD, {24'h0, per});
    rc(OFF_PERIOD, {24'h0, per});
    wr(OFF_COUNT, 32'h37);
    repeat (40) @(posedge clk);
    rc(OFF_COUNT, 32'h37);
    wstrb <= 4'he;
    wr(OFF_COUNT, 32'h11);
    wstrb <= 4'hf;
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rc(OFF_COUNT, 32'h37);
    wr(OFF_CONTROL, 32'h7a);
    rc(OFF_COUNT, 32'h37);
    wr(OFF_CONTROL, 32'hff);
    rc(OFF_CONTROL, 32'h7f);
    done("registers");
    for (int ps = 0; ps < 4; ps++) begin
      per = ps == 0 ? 8'h00 : ps == 1 ? 8'hff : 8'(($unsigned($random(seed)) % 4) + 1);
      post = 4'($random(seed));
      wr(OFF_PERIOD, {24'h0, per});
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, {24'h0, 1'b0, post, 1'b1, 2'(ps)});
      pulse_gap();
      chk(32'(g), 32'(gap(per, 2'(ps))));
    end
    done("prescale");
    wr(OFF_PERIOD, 32'h0);
    wr(OFF_MASK, 32'h2);
    for (int i = 0; i < 3; i++) begin
      post = i == 0 ? 4'h0 : i == 1 ? 4'hf : 4'($random(seed));
      wr(OFF_CONTROL, 32'h0);
      rd(OFF_STATUS);
      wr(OFF_CONTROL, {24'h0, 1'b0, post, 3'b100});
      n = 0;
      g = 0;
      do begin
        @(posedge clk);
        n += int'(serialMatchPulse);
        g++;
      end while (!irq && g < 2000);
      chk(32'(n), 32'(post) + 32'h1);
    end
    repeat (200) @(posedge clk);
    wr(OFF_CONTROL, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(OFF_MASK, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h1);
    rc(OFF_STATUS, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h0);
    rc(OFF_STATUS, 32'h0);
    done("postscale");
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CONTROL, 32'h7e);
      repeat (200 + $unsigned($random(seed)) % 500) @(posedge clk);
      wr(i == 0 ? OFF_COUNT : OFF_CONTROL, i == 0 ? 32'h0 : 32'h7e);
      rd(OFF_STATE);
      chk({28'h0, rdv[7:4]}, 32'h0);
      chk({31'h0, rdv[3:0] <= 4'h3}, 32'h1);
    end
    done("scaler clear");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    reset_vals();
    done("second reset");
    report_and_stop();
  end
endmodule
bind period_match_timer8 period_match_timer8_props u_props (.clk(clk), .reset(reset),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
  .serialMatchPulse(serialMatchPulse), .pwmPeriodPulse(pwmPeriodPulse), .pwmCount(pwmCount));
